// *** hw/iod_diag_record.sv ***
/*
  Diagnostic record of a four-channel analog output module. Holds the
  channel error state, builds the record bytes and serves byte reads by
  record set and index. Stamps the microsecond count each time a channel turns faulty.
  Record layout, by byte index:
    0        general diagnostic byte
    1 to 5   fixed module and channel description bytes; 2 and 3 read as zero
    6        channel count
    7        channel error summary, one bit per channel
    8 to 11  per-channel error bytes
    12 to 15 reserved, read as zero
    16 to 19 timestamp, least significant byte first
  Assumes error levels arrive from the output stage asynchronously and the
  reader issues one request per cycle at most. The timestamp is read byte by
  byte with no snapshot, so a reader racing a new error may see mixed bytes.
*/
`timescale 1ns/1ps

module iod_diag_record
  import iod_pkg::*;
#(
  parameter int unsigned NCH = 4
) (
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  input  wire logic [NCH-1:0]  ch_param_err,
  input  wire logic [NCH-1:0]  ch_short_gnd,
  input  wire logic            rd_req,
  input  iod_pkg::iod_req_t    rd_addr,
  output logic                 rd_valid,
  output logic                 rd_err,
  output logic [7:0]           rd_data,
  output logic                 diag_event
);
  import iod_pkg::*;

  // ==========================================================================
  // Internal signals

  // Error level synchronisers, first and second stage
  logic [NCH-1:0] par_s1_q;
  logic [NCH-1:0] par_s2_q;
  logic [NCH-1:0] short_s1_q;
  logic [NCH-1:0] short_s2_q;

  // Channel error state and event edge
  logic [NCH-1:0] any_prev_q;     // Channel errors one cycle ago
  logic [NCH-1:0] any_err;        // Channel has any error now
  logic [NCH-1:0] new_err;        // Channel error just appeared
  logic           par_any;        // Some channel has a parameter error

  // Time base and captured stamp
  logic [31:0]    us_count;
  logic [31:0]    stamp_q;
  logic           event_q;

  // Record bytes
  logic [7:0]     chbyte [NCH];
  logic [7:0]     general_byte;
  logic [7:0]     summary_byte;
  logic [7:0]     stamp_byte;
  logic [7:0]     chan_byte;
  logic [7:0]     rec_byte;
  logic           in_range;

  // Registered answer
  logic           valid_q;
  logic           err_q;
  logic [7:0]     data_q;

  // ==========================================================================
  // Time base
  iod_us_ticker u_ticker (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .us_count (us_count)
  );

  // ==========================================================================
  // Two-stage synchronisers for the error levels; only stage two is read
  // Parameter assignment errors
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      par_s1_q <= '0;
      par_s2_q <= '0;
    end else begin
      par_s1_q <= ch_param_err;
      par_s2_q <= par_s1_q;
    end
  end

  // Shorts to ground
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      short_s1_q <= '0;
      short_s2_q <= '0;
    end else begin
      short_s1_q <= ch_short_gnd;
      short_s2_q <= short_s1_q;
    end
  end

  // Per-channel error bytes and group summary
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      always_comb begin
        chbyte[g] = 8'h00;
        chbyte[g][BIT_CH_PARERR] = par_s2_q[g];
        chbyte[g][BIT_CH_SHORT]  = short_s2_q[g];
      end
      assign any_err[g] = par_s2_q[g] | short_s2_q[g];
      assign new_err[g] = any_err[g] & ~any_prev_q[g]; // Rising channel error
    end
  endgenerate

  // Any parameter error, reported in the general byte
  assign par_any = |par_s2_q;

  // ==========================================================================
  // Event detection: a channel turning faulty stamps the time
  // Previous error state and the event strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      any_prev_q <= '0;
      event_q    <= 1'b0;
    end else begin
      any_prev_q <= any_err;
      event_q    <= |new_err;
    end
  end

  // Stamp held until a channel next turns faulty; each such turn restamps
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stamp_q <= 32'h0000_0000;
    end else if (|new_err) begin
      stamp_q <= us_count;
    end
  end

  // ==========================================================================
  // Record byte lookup
  // General byte: channel error mirror and parameter error flag
  always_comb begin
    general_byte                 = 8'h00;
    general_byte[BIT_GEN_CHANNEL_ERROR_SUMMARY]  = |any_err;
    general_byte[BIT_GEN_PARERR] = par_any;
  end

  // Summary byte: one bit per channel, upper bits reserved
  always_comb begin
    summary_byte          = 8'h00;
    summary_byte[NCH-1:0] = any_err;
  end

  // Timestamp byte picked by the low index bits, least significant first
  always_comb begin
    stamp_byte = stamp_q[{rd_addr.index[1:0], 3'b000} +: 8];
  end

  // Channel byte picked by the low index bits
  always_comb begin
    chan_byte = chbyte[rd_addr.index[1:0]];
  end

  // Byte at the requested index; gaps and reserved bytes read zero
  always_comb begin
    rec_byte = 8'h00;
    if (rd_addr.index >= OFS_STAMP0 && rd_addr.index < FULL_LEN) begin
      rec_byte = stamp_byte;
    end else if (rd_addr.index >= OFS_CHERR0 && rd_addr.index < OFS_CHRES0) begin
      rec_byte = chan_byte;
    end else begin
      unique case (rd_addr.index)
        OFS_GENERAL:  rec_byte = general_byte;
        OFS_MODINFO:  rec_byte = VAL_MODINFO;
        OFS_CHTYPE:   rec_byte = VAL_CHTYPE;
        OFS_DIAGBITS: rec_byte = VAL_DIAGBITS;
        OFS_CHCOUNT:  rec_byte = VAL_CHCOUNT;
        OFS_SUMMARY:  rec_byte = summary_byte;
        default:      rec_byte = 8'h00;
      endcase
    end
  end

  // Which set reaches how far into the record
  always_comb begin
    unique case (rd_addr.set_num)
      SET_FULL: in_range = rd_addr.index < FULL_LEN;
      SET_HEAD: in_range = rd_addr.index < HEAD_LEN;
      default:  in_range = 1'b0;
    endcase
  end

  // ==========================================================================
  // Registered read answer, one cycle after the request
  // Answer strobe and refusal flag, one cycle each per request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      valid_q <= rd_req;
      err_q   <= rd_req & ~in_range;
    end
  end

  // Answer byte; zero when idle or refused, so stale bytes never linger
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      data_q <= 8'h00;
    end else if (rd_req && in_range) begin
      data_q <= rec_byte;
    end else begin
      data_q <= 8'h00;
    end
  end

  assign rd_valid   = valid_q;
  assign rd_err     = err_q;
  assign rd_data    = data_q;
  assign diag_event = event_q;

endmodule

// *** hw/iod_pkg.sv ***
/*
  Package of the diagnostic record block: record layout, fixed field values,
  timing counts and the read request carrier.
  Assumes a single 100 MHz core clock.
*/
package iod_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned CYCLES_PER_US  = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Record sets
  localparam logic [7:0] SET_HEAD = 8'h00;  // First four bytes only
  localparam logic [7:0] SET_FULL = 8'h01;  // Whole record

  // ==========================================================================
  // Byte offsets within the record
  localparam logic [4:0] OFS_GENERAL   = 5'h00;
  localparam logic [4:0] OFS_MODINFO   = 5'h01;
  localparam logic [4:0] OFS_RES_C     = 5'h02;
  localparam logic [4:0] OFS_INTERNAL  = 5'h03;
  localparam logic [4:0] OFS_CHTYPE    = 5'h04;
  localparam logic [4:0] OFS_DIAGBITS  = 5'h05;
  localparam logic [4:0] OFS_CHCOUNT   = 5'h06;
  localparam logic [4:0] OFS_SUMMARY   = 5'h07;
  localparam logic [4:0] OFS_CHERR0    = 5'h08;
  localparam logic [4:0] OFS_CHRES0    = 5'h0C;
  localparam logic [4:0] OFS_STAMP0    = 5'h10;
  localparam logic [4:0] HEAD_LEN      = 5'h04;
  localparam logic [4:0] FULL_LEN      = 5'h14;

  // ==========================================================================
  // Fixed field values
  localparam logic [7:0] VAL_MODINFO   = 8'h15;
  localparam logic [7:0] VAL_CHTYPE    = 8'h73;
  localparam logic [7:0] VAL_DIAGBITS  = 8'h08;
  localparam logic [7:0] VAL_CHCOUNT   = 8'h04;

  // ==========================================================================
  // Bit positions
  localparam int unsigned BIT_GEN_CHANNEL_ERROR_SUMMARY   = 3;  // General byte: any channel error
  localparam int unsigned BIT_GEN_PARERR  = 7;  // General byte: parameter error
  localparam int unsigned BIT_CH_PARERR   = 0;  // Channel byte: parameter error
  localparam int unsigned BIT_CH_SHORT    = 3;  // Channel byte: short to ground

  // ==========================================================================
  // Read request carrier
  typedef struct packed {
    logic [7:0] set_num;
    logic [4:0] index;
  } iod_req_t;

endpackage

// *** hw/iod_us_ticker.sv ***
/*
  Free-running microsecond ticker: a prescaler of core clocks and a 32-bit
  count that wraps.
  Assumes synchronous active-high reset applied at power-on.
*/
`timescale 1ns/1ps
module iod_us_ticker
  import iod_pkg::*;
#(
  parameter int unsigned DIV = CYCLES_PER_US
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  output logic [31:0]      us_count
);

  localparam int unsigned PW = $clog2(DIV + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(DIV - 1);

  logic [PW-1:0] pre_q;
  logic [31:0]   us_q;

  // ==========================================================================
  // Prescaler, one microsecond per wrap
  always_ff @(posedge core_clk) begin
    if (sys_rst || pre_q == PRE_LAST) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end

  // Count from zero at power-on, natural wrap past all ones
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      us_q <= 32'h0000_0000;
    end else if (pre_q == PRE_LAST) begin
      us_q <= us_q + 32'h0000_0001;
    end
  end

  assign us_count = us_q;

endmodule

// *** tb/iod_asserts.sv ***
/* Checker of the record read port.
   Assumes it is bound to the record block. */
`timescale 1ns/1ps
module iod_chk
  import iod_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         sys_rst,
  input wire logic         rd_req,
  input iod_pkg::iod_req_t rd_addr,
  input wire logic         rd_valid,
  input wire logic         rd_err,
  input wire logic [7:0]   rd_data,
  input wire logic         diag_event
);
  // ==========================================
  // Read port checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ans_next_a: assert property (rd_req |=> rd_valid) else $error("no answer");
  idle_quiet_a: assert property (!rd_req |=> !rd_valid && !rd_err && rd_data == 8'h00)
    else $error("answer without request");
  chan_count_a: assert property (rd_req && rd_addr == {SET_FULL, OFS_CHCOUNT} |=> rd_data == 8'h04)
    else $error("channel count");
  summary_res_a: assert property (rd_req && rd_addr == {SET_FULL, OFS_SUMMARY} |=> rd_data[7:4] == 4'h0)
    else $error("summary reserved");
  chan_res_a: assert property (rd_req && rd_addr.set_num == SET_FULL && rd_addr.index inside {[8:11]}
    |=> (rd_data & 8'hF6) == 8'h00) else $error("channel reserved");
  bad_set_a: assert property (rd_req && rd_addr.set_num > SET_FULL |=> rd_err && rd_data == 8'h00)
    else $error("bad set served");
  head_len_a: assert property (rd_req && rd_addr.set_num == SET_HEAD && rd_addr.index >= HEAD_LEN
    |=> rd_err) else $error("head overrun");
  full_ok_a: assert property (rd_req && rd_addr.set_num == SET_FULL && rd_addr.index < FULL_LEN
    |=> !rd_err) else $error("full read refused");
  cover property (rd_req && rd_addr.set_num == SET_HEAD);
  cover property (rd_err);
  cover property (diag_event);
endmodule
bind iod_diag_record iod_chk chk (.core_clk(core_clk), .sys_rst(sys_rst), .rd_req(rd_req),
  .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data), .diag_event(diag_event));

// *** tb/iod_diag_record_test.sv ***
/* Self-checking bench of the record block.
   Assumes the reader model and the checker. */
`timescale 1ns/1ps
module iod_diag_record_test;
  import iod_pkg::*;
  logic       core_clk, sys_rst, go, rd_req, rd_valid, rd_err, diag_event;
  logic [3:0] pe, sg;
  logic [7:0] rd_data;
  iod_req_t   want, rd_addr;
  int         errors, n_checks, cyc, seed, lo, st, ev, old;
  iod_diag_record dut (.core_clk(core_clk), .sys_rst(sys_rst), .ch_param_err(pe), .ch_short_gnd(sg),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data),
    .diag_event(diag_event));
  iod_reader rdr (.core_clk(core_clk), .go(go), .want(want), .rd_req(rd_req), .rd_addr(rd_addr));
  // ==========================================
  // Clock and cycle count
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= sys_rst ? 0 : cyc + 1;
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Expected byte, -1 when refused
  function automatic int model(int s, int i);
    if (s > 1 || i >= (s ? 20 : 4)) return -1;
    case (i)
      0: return ((pe | sg) != 0 ? 8 : 0) | (pe != 0 ? 128 : 0);
      1: return VAL_MODINFO;
      4: return VAL_CHTYPE;
      5: return VAL_DIAGBITS;
      6: return 4;
      7: return pe | sg;
      8, 9, 10, 11: return {sg[i-8], 2'b00, pe[i-8]};
      default: return 0;
    endcase
  endfunction
  task automatic rd(input int s, i, output logic [7:0] d, output logic e);
    want = {s[7:0], i[4:0]};
    go = 1;
    @(posedge core_clk) #1 go = 0;
    for (int w = 0; w < 4 && rd_valid !== 1'b1; w++) @(posedge core_clk) #1;
    if (rd_valid !== 1'b1) begin
      errors++;
      print_verdict();
    end
    d = rd_data;
    e = rd_err;
  endtask
  task automatic rdchk(input int s, i);
    logic [7:0] d;
    logic       e;
    int         m;
    rd(s, i, d, e);
    m = model(s, i);
    chk({e, d}, m < 0 ? 9'h100 : m);
  endtask
  task automatic stamp();
    logic [7:0] d;
    logic       e;
    int         v;
    v = 0;
    for (int i = 19; i >= 16; i--) begin
      rd(1, i, d, e);
      v = v << 8 | d;
    end
    chk(v >= lo && v <= lo + 1, 1);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    seed = 18172;
    go = 0;
    want = '0;
    pe = 0;
    sg = 0;
    sys_rst = 1;
    repeat (8) @(posedge core_clk);
    #1 sys_rst = 0;
    lo = 0;
    stamp();
    for (int n = 0; n < 12; n++) begin
      old = pe | sg;
      repeat (($random(seed) & 255) + 50) @(posedge core_clk);
      #1 {pe, sg} = (n % 4 == 3) ? 8'h00 : 8'($random(seed));
      st = cyc;
      ev = 0;
      repeat (6) @(posedge core_clk) #1 ev |= diag_event;
      chk(ev, ((pe | sg) & ~old) != 0);
      if (ev) lo = (st + 1) / 100;
      for (int s = 0; s < 3; s++)
        for (int i = 0; i < 24; i++)
          if (i < 16 || i > 19 || s != 1) rdchk(s, i);
      stamp();
    end
    print_verdict();
  end
endmodule

// *** tb/iod_reader.sv ***
/* Controller model issuing record reads.
   Assumes go is raised just after an edge. */
`timescale 1ns/1ps
module iod_reader
  import iod_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        go,
  input  iod_pkg::iod_req_t want,
  output logic             rd_req,
  output iod_pkg::iod_req_t rd_addr
);
  initial rd_req = 1'b0;
  initial rd_addr = '0;
  // Request after the edge; idle address scrambled
  always @(posedge core_clk) begin
    rd_req <= #1 go;
    rd_addr <= #1 go ? want : ~rd_addr;
  end
endmodule
